// ---- core/khc_host_command.sv ----
// host command decoder with port pins, edge interrupts and event queue
`timescale 1ns/100ps
// Behaviour
// RL1: pin state from direction and output bits
// RL2: pin three pulls up whenever input
// RL3: command d1 enables pin edge interrupts
// RL4: every enabled pin edge asserts interrupt
// RL5: enabled pin edge wakes from halt
// RL6: one enabled pin sets both edge bits
// RL7: 0x20 returns queued events and pops
// RL8: 0x21 replays last read, no pop
// RL9: 0x22 sets debounce, zero ignored
// RL10: 0x30 returns pin levels, upper zero
// RL11: 0x31 loads per-pin output bits
// RL12: 0x32 loads per-pin direction bits
// RL13: 0x40 loads first pulse phase length
// RL14: 0x41 loads second pulse phase length
// RL15: 0x42 loads three pulse control bits
// RL16: 0xd0 returns and clears interrupt code
// RL17: 0xe3 requests a keypad rescan
// RL18: 0xe4 sets inactivity time before halt
// RL19: host keeps active time above debounce
// RL20: 0xf0 returns and clears error code
// RL21: interrupt code bit layout
// RL22: 0xe0 returns the status code
// RL23: byte after write address is command
// RL24: undefined data bits ignored, read zero
// RL25: unknown command raises error flag
module khc_host_command #(
  parameter int STEP_CYCLES = khc_pkg::STEP_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // two-wire host bus
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  output logic irqN,
  // port pins
  input wire logic [3:0] pinIn,
  output logic [3:0] pinOut,
  output logic [3:0] pinOe_n,
  output logic [3:0] pinPullup,
  // key scan engine
  input wire logic keyEvtValid,
  input wire logic [7:0] keyEvtCode,
  input wire logic keyOverrun,
  output logic scanReq,
  output logic [7:0] debounceTime,
  output logic [7:0] activeTime,
  output logic halted,
  // pulse output timing
  output logic [15:0] phaseATime,
  output logic [15:0] phaseBTime,
  output logic [2:0] pulseCtrl,
  output logic pulseCtrlStrobe
);
  // ----------------------------------------------------------------
  // input synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [5:0] sync1_r, sync2_r, prev_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_r <= 6'h3f;
      sync2_r <= 6'h3f;
      prev_r <= 6'h3f;
    end else begin
      sync1_r <= {pinIn, sdaIn, sclIn};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end
  logic sclS, sdaS, sclRise, sclFall, busStart, busStop;
  logic [3:0] pinS;
  assign sclS = sync2_r[0];
  assign sdaS = sync2_r[1];
  assign pinS = sync2_r[5:2];
  assign sclRise = sclS & ~prev_r[0];
  assign sclFall = ~sclS & prev_r[0];
  assign busStart = sclS & prev_r[0] & prev_r[1] & ~sdaS;
  assign busStop = sclS & prev_r[0] & ~prev_r[1] & sdaS;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic awHeld_r, wHeld_r, busEnable_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic [31:0] statusWord;
  logic [3:0] qCount_r;
  logic [7:0] intCode_r, errCode_r, statCode_r;
  assign awready = ~awHeld_r & ~bvalid;
  assign wready = ~wHeld_r & ~bvalid;
  assign arready = ~rvalid;
  assign statusWord = {3'h0, halted, qCount_r, errCode_r, intCode_r, statCode_r};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      bvalid <= 1'b0;
      bresp <= khc_pkg::RESP_OKAY;
      busEnable_r <= 1'b1;
    end else begin
      if (awvalid && awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
      if (awHeld_r && wHeld_r && !bvalid) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bvalid <= 1'b1;
        if (awAddr_r == khc_pkg::REG_CTRL) begin
          bresp <= khc_pkg::RESP_OKAY;
          if (wStrb_r[0]) busEnable_r <= wData_r[0];
        end else begin
          bresp <= (awAddr_r == khc_pkg::REG_STATUS) ? khc_pkg::RESP_OKAY : khc_pkg::RESP_SLVERR;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= khc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= khc_pkg::RESP_OKAY;
      if (araddr == khc_pkg::REG_CTRL) rdata <= {31'h0, busEnable_r};
      else if (araddr == khc_pkg::REG_STATUS) rdata <= statusWord;
      else begin
        rdata <= 32'h0;
        rresp <= khc_pkg::RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // two-wire byte engine
  // ----------------------------------------------------------------
  khc_pkg::khc_bus_state_t state_r;
  logic [3:0] bitCnt_r;
  logic ackPhase_r, sdaOeN_r;
  logic [7:0] rxShift_r, txShift_r, txSel, cmd_r;
  logic [4:0] byteIdx_r, txIdx_r;
  logic byteDone, rxCmdByte, rxDataByte, txLoad, addrMatch;
  assign byteDone = (state_r != khc_pkg::BUS_IDLE) && sclFall && !ackPhase_r && (bitCnt_r == 4'h8);
  assign addrMatch = rxShift_r[7:1] == khc_pkg::SLAVE_ADDR;
  assign rxCmdByte = byteDone && (state_r == khc_pkg::BUS_RX) && (byteIdx_r == 5'h0); // [RL23]
  assign rxDataByte = byteDone && (state_r == khc_pkg::BUS_RX) && (byteIdx_r != 5'h0);
  assign txLoad = sclFall && ackPhase_r && (state_r == khc_pkg::BUS_TX);
  assign sdaOut = 1'b0;
  assign sdaOe_n = sdaOeN_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= khc_pkg::BUS_IDLE;
      bitCnt_r <= 4'h0;
      ackPhase_r <= 1'b0;
      sdaOeN_r <= 1'b1;
      rxShift_r <= 8'h00;
      txShift_r <= 8'h00;
      byteIdx_r <= 5'h0;
      txIdx_r <= 5'h0;
    end else if (busStart && busEnable_r) begin
      state_r <= khc_pkg::BUS_ADDR;
      bitCnt_r <= 4'h0;
      ackPhase_r <= 1'b0;
      sdaOeN_r <= 1'b1;
      byteIdx_r <= 5'h0;
      txIdx_r <= 5'h0;
    end else if (busStop) begin
      state_r <= khc_pkg::BUS_IDLE;
      sdaOeN_r <= 1'b1;
    end else if (state_r != khc_pkg::BUS_IDLE) begin
      if (sclRise) begin
        if (!ackPhase_r) begin
          rxShift_r <= {rxShift_r[6:0], sdaS};
          bitCnt_r <= bitCnt_r + 4'h1;
        end else if (state_r == khc_pkg::BUS_TX && sdaS) begin
          // master refused the byte: release the line and wait for stop
          state_r <= khc_pkg::BUS_IDLE;
        end
      end else if (byteDone) begin
        ackPhase_r <= 1'b1;
        sdaOeN_r <= 1'b1;
        case (state_r)
          khc_pkg::BUS_ADDR: begin
            if (!addrMatch) state_r <= khc_pkg::BUS_IDLE;
            else begin
              sdaOeN_r <= 1'b0;
              state_r <= rxShift_r[0] ? khc_pkg::BUS_TX : khc_pkg::BUS_RX;
            end
          end
          khc_pkg::BUS_RX: begin
            sdaOeN_r <= 1'b0;
            if (byteIdx_r != 5'h1f) byteIdx_r <= byteIdx_r + 5'h1;
          end
          default: sdaOeN_r <= 1'b1;
        endcase
      end else if (sclFall) begin
        if (ackPhase_r) begin
          ackPhase_r <= 1'b0;
          bitCnt_r <= 4'h0;
          sdaOeN_r <= 1'b1;
          if (state_r == khc_pkg::BUS_TX) begin
            txShift_r <= txSel;
            sdaOeN_r <= txSel[7];
            if (txIdx_r != 5'h1f) txIdx_r <= txIdx_r + 5'h1;
          end
        end else if (state_r == khc_pkg::BUS_TX) begin
          txShift_r <= {txShift_r[6:0], 1'b0};
          sdaOeN_r <= txShift_r[6];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // command decode and write commands
  // ----------------------------------------------------------------
  logic cmdKnown;
  logic [3:0] portOut_r, portDir_r;
  logic [1:0] edgeEn_r;
  logic [7:0] phaseHold_r;
  always_comb begin
    case (rxShift_r)
      khc_pkg::CMD_QUEUE_READ, khc_pkg::CMD_QUEUE_REREAD, khc_pkg::CMD_DEBOUNCE, khc_pkg::CMD_PORT_IN,
      khc_pkg::CMD_PORT_OUT, khc_pkg::CMD_PORT_DIR, khc_pkg::CMD_PHASE_A, khc_pkg::CMD_PHASE_B,
      khc_pkg::CMD_PULSE_CTRL, khc_pkg::CMD_READ_INT, khc_pkg::CMD_EDGE_IRQ, khc_pkg::CMD_READ_STATUS,
      khc_pkg::CMD_SCAN_REQ, khc_pkg::CMD_ACTIVE, khc_pkg::CMD_READ_ERROR: cmdKnown = 1'b1;
      default: cmdKnown = 1'b0;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_r <= 8'h00;
      scanReq <= 1'b0;
      pulseCtrlStrobe <= 1'b0;
      debounceTime <= khc_pkg::DEBOUNCE_DEFAULT;
      activeTime <= khc_pkg::ACTIVE_DEFAULT;
      portOut_r <= 4'h0;
      portDir_r <= 4'h0;
      edgeEn_r <= 2'h0;
      phaseHold_r <= 8'h00;
      phaseATime <= 16'h0;
      phaseBTime <= 16'h0;
      pulseCtrl <= 3'h0;
    end else begin
      scanReq <= rxCmdByte && (rxShift_r == khc_pkg::CMD_SCAN_REQ); // [RL17]
      pulseCtrlStrobe <= 1'b0;
      if (rxCmdByte) cmd_r <= rxShift_r; // [RL23]
      if (rxDataByte) begin
        case (cmd_r)
          // zero is outside the valid range, so it leaves the setting alone
          khc_pkg::CMD_DEBOUNCE: if (rxShift_r != 8'h00) debounceTime <= rxShift_r; // [RL9]
          khc_pkg::CMD_ACTIVE: if (rxShift_r != 8'h00) activeTime <= rxShift_r; // [RL18]
          khc_pkg::CMD_PORT_OUT: portOut_r <= rxShift_r[3:0]; // [RL11] [RL24]
          khc_pkg::CMD_PORT_DIR: portDir_r <= rxShift_r[3:0]; // [RL12] [RL24]
          khc_pkg::CMD_EDGE_IRQ: edgeEn_r <= rxShift_r[1:0]; // [RL3] [RL24]
          khc_pkg::CMD_PHASE_A, khc_pkg::CMD_PHASE_B: begin
            // high byte first; the value commits on the low byte
            if (byteIdx_r == 5'h1) phaseHold_r <= rxShift_r;
            else if (byteIdx_r == 5'h2 && cmd_r == khc_pkg::CMD_PHASE_A) phaseATime <= {phaseHold_r, rxShift_r}; // [RL13]
            else if (byteIdx_r == 5'h2) phaseBTime <= {phaseHold_r, rxShift_r}; // [RL14]
          end
          khc_pkg::CMD_PULSE_CTRL: begin
            pulseCtrl <= rxShift_r[2:0]; // [RL15] [RL24]
            pulseCtrlStrobe <= 1'b1;
          end
          default: pulseCtrlStrobe <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // port pins and edge detection
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      assign pinOut[gi] = portOut_r[gi]; // [RL1]
      assign pinOe_n[gi] = ~portDir_r[gi]; // [RL1]
      if (gi == khc_pkg::PULLUP_ONLY_PIN) begin : g_pu
        assign pinPullup[gi] = ~portDir_r[gi]; // [RL2]
      end else begin : g_sel
        assign pinPullup[gi] = ~portDir_r[gi] & portOut_r[gi]; // [RL1]
      end
    end
  endgenerate
  logic [1:0] pinEdge;
  logic edgeAny;
  assign pinEdge = (pinS[1:0] ^ prev_r[3:2]) & edgeEn_r; // [RL4]
  assign edgeAny = |pinEdge;

  // ----------------------------------------------------------------
  // event queue
  // ----------------------------------------------------------------
  logic [7:0] queueMem_r [16];
  logic [3:0] wrPtr_r, rdPtr_r, replayBase_r;
  logic [4:0] replayLen_r;
  logic push, pop, firstByte;
  assign push = keyEvtValid && (qCount_r != khc_pkg::QUEUE_MAX);
  assign firstByte = txIdx_r == 5'h0;
  assign pop = txLoad && (cmd_r == khc_pkg::CMD_QUEUE_READ) && (txIdx_r < khc_pkg::READ_MAX_BYTES)
               && (qCount_r != 4'h0); // [RL7]
  always_ff @(posedge clk) begin
    if (push) queueMem_r[wrPtr_r] <= keyEvtCode;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_r <= 4'h0;
      rdPtr_r <= 4'h0;
      qCount_r <= 4'h0;
      replayBase_r <= 4'h0;
      replayLen_r <= 5'h0;
    end else begin
      if (push) wrPtr_r <= wrPtr_r + 4'h1;
      if (pop) rdPtr_r <= rdPtr_r + 4'h1;
      if (push && !pop) qCount_r <= qCount_r + 4'h1;
      else if (pop && !push) qCount_r <= qCount_r - 4'h1;
      // remember where the last queue read began so it can be replayed
      if (txLoad && cmd_r == khc_pkg::CMD_QUEUE_READ) begin
        if (firstByte) begin
          replayBase_r <= rdPtr_r; // [RL8]
          replayLen_r <= {4'h0, pop};
        end else if (pop) begin
          replayLen_r <= replayLen_r + 5'h1;
        end
      end
    end
  end
  // a replay after new events wrapped the buffer may show overwritten slots
  logic [3:0] replayIdx;
  assign replayIdx = replayBase_r + txIdx_r[3:0];
  always_comb begin
    case (cmd_r)
      khc_pkg::CMD_QUEUE_READ: txSel = pop ? queueMem_r[rdPtr_r] : 8'h00; // [RL7]
      khc_pkg::CMD_QUEUE_REREAD: txSel = (txIdx_r < replayLen_r) ? queueMem_r[replayIdx] : 8'h00; // [RL8]
      khc_pkg::CMD_PORT_IN: txSel = {4'h0, pinS}; // [RL10]
      khc_pkg::CMD_READ_INT: txSel = {4'h0, intCode_r[3:0]}; // [RL16] [RL24]
      khc_pkg::CMD_READ_STATUS: txSel = {3'h0, statCode_r[4:0]}; // [RL22]
      khc_pkg::CMD_READ_ERROR: txSel = {1'b0, errCode_r[6:0]}; // [RL20]
      default: txSel = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // interrupt, error and status codes
  // ----------------------------------------------------------------
  logic [7:0] errSet, intSet;
  logic intClr, errClr, cmdUnknown;
  assign cmdUnknown = rxCmdByte && !cmdKnown;
  assign intClr = txLoad && (cmd_r == khc_pkg::CMD_READ_INT);
  assign errClr = txLoad && (cmd_r == khc_pkg::CMD_READ_ERROR);
  always_comb begin
    errSet = 8'h00;
    errSet[khc_pkg::ERR_CMDUNK] = cmdUnknown; // [RL25]
    errSet[khc_pkg::ERR_KEYOVR] = keyOverrun;
    errSet[khc_pkg::ERR_FIFOOVR] = keyEvtValid && !push;
    intSet = 8'h00;
    intSet[khc_pkg::INT_KEY] = push; // [RL21]
    intSet[khc_pkg::INT_ERROR] = |errSet; // [RL21]
    if (&edgeEn_r) begin
      intSet[khc_pkg::INT_EDGE0] = pinEdge[0]; // [RL6]
      intSet[khc_pkg::INT_EDGE1] = pinEdge[1]; // [RL6]
    end else begin
      intSet[khc_pkg::INT_EDGE0] = edgeAny; // [RL6]
      intSet[khc_pkg::INT_EDGE1] = edgeAny; // [RL6]
    end
  end
  // new events win over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      intCode_r <= 8'h00;
      errCode_r <= 8'h00;
      irqN <= 1'b1;
    end else begin
      intCode_r <= (intClr ? 8'h00 : intCode_r) | intSet; // [RL16]
      errCode_r <= (errClr ? 8'h00 : errCode_r) | errSet; // [RL20]
      irqN <= ~|((intClr ? 8'h00 : intCode_r) | intSet); // [RL4] [RL16]
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) statCode_r <= khc_pkg::STAT_RESET;
    else if (halted && edgeAny) statCode_r <= khc_pkg::STAT_WAKE;
    else if (rxCmdByte) statCode_r <= cmdKnown ? khc_pkg::STAT_ACK : khc_pkg::STAT_NOACK;
  end

  // ----------------------------------------------------------------
  // inactivity timer and halt
  // ----------------------------------------------------------------
  // the host keeps the active time above the debounce time [RL19]
  logic [31:0] stepCnt_r;
  logic [7:0] idleSteps_r;
  logic step, activity;
  assign step = stepCnt_r == 32'(STEP_CYCLES - 1);
  assign activity = keyEvtValid | busStart | edgeAny | ~irqN;
  always_ff @(posedge clk) begin
    if (!rst_n) stepCnt_r <= 32'h0;
    else if (step) stepCnt_r <= 32'h0;
    else stepCnt_r <= stepCnt_r + 32'h1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idleSteps_r <= 8'h00;
      halted <= 1'b0;
    end else if (activity) begin
      idleSteps_r <= 8'h00;
      halted <= 1'b0; // [RL5]
    end else if (step && !halted) begin
      if (idleSteps_r >= activeTime) halted <= 1'b1; // [RL18]
      else idleSteps_r <= idleSteps_r + 8'h01;
    end
  end
endmodule : khc_host_command

// ---- core/khc_pkg.sv ----
// constants shared by the host command decoder
package khc_pkg;
  // ----------------------------------------------------------------
  // bus-side slave address and command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h51;
  localparam logic [7:0] CMD_QUEUE_READ = 8'h20;
  localparam logic [7:0] CMD_QUEUE_REREAD = 8'h21;
  localparam logic [7:0] CMD_DEBOUNCE = 8'h22;
  localparam logic [7:0] CMD_PORT_IN = 8'h30;
  localparam logic [7:0] CMD_PORT_OUT = 8'h31;
  localparam logic [7:0] CMD_PORT_DIR = 8'h32;
  localparam logic [7:0] CMD_PHASE_A = 8'h40;
  localparam logic [7:0] CMD_PHASE_B = 8'h41;
  localparam logic [7:0] CMD_PULSE_CTRL = 8'h42;
  localparam logic [7:0] CMD_READ_INT = 8'hd0;
  localparam logic [7:0] CMD_EDGE_IRQ = 8'hd1;
  localparam logic [7:0] CMD_READ_STATUS = 8'he0;
  localparam logic [7:0] CMD_SCAN_REQ = 8'he3;
  localparam logic [7:0] CMD_ACTIVE = 8'he4;
  localparam logic [7:0] CMD_READ_ERROR = 8'hf0;
  // ----------------------------------------------------------------
  // code layouts and reset values
  // ----------------------------------------------------------------
  localparam int INT_KEY = 0;
  localparam int INT_EDGE0 = 1;
  localparam int INT_EDGE1 = 2;
  localparam int INT_ERROR = 3;
  localparam int ERR_CMDUNK = 1;
  localparam int ERR_KEYOVR = 2;
  localparam int ERR_FIFOOVR = 6;
  localparam int PULLUP_ONLY_PIN = 3;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] STAT_WAKE = 8'h02;
  localparam logic [7:0] STAT_ACK = 8'h06;
  localparam logic [7:0] STAT_NOACK = 8'h15;
  localparam logic [7:0] DEBOUNCE_DEFAULT = 8'h03;
  localparam logic [7:0] ACTIVE_DEFAULT = 8'ha7;
  localparam logic [3:0] QUEUE_MAX = 4'he;
  localparam logic [4:0] READ_MAX_BYTES = 5'h10;
  // ----------------------------------------------------------------
  // timing: one halt-timer step is 3 ms
  // ----------------------------------------------------------------
  localparam int STEP_MS = 3;
  localparam int CLK_KHZ = 100000;
  localparam int STEP_CYCLES = STEP_MS * CLK_KHZ;
  // ----------------------------------------------------------------
  // AXI4-Lite register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {BUS_IDLE, BUS_ADDR, BUS_RX, BUS_TX} khc_bus_state_t;
endpackage : khc_pkg

// ---- tb/khc_host_command_props.sv ----
// port-level assertions for the host command decoder
`timescale 1ns/100ps
module khc_host_command_props (
  // clock, reset and register bus
  input wire logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready,
  input wire logic rvalid, rready,
  input wire logic [1:0] bresp,
  input wire logic [31:0] rdata,
  // pins, key engine and pulse control
  input wire logic irqN, keyEvtValid, keyOverrun, scanReq, pulseCtrlStrobe,
  input wire logic [3:0] pinOut, pinOe_n, pinPullup,
  input wire logic [7:0] debounceTime, activeTime
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd;
    arvalid && arready;
  endsequence
  AST_BRESP: assert property (s_wr |=> ##1 bvalid) else $error("no bresp");
  AST_BHOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
  AST_RRESP: assert property (s_rd |=> rvalid) else $error("no rvalid");
  AST_RHOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata dropped");
  AST_PIN3: assert property (pinOe_n[3] |-> pinPullup[3]) else $error("pin 3 floats");
  AST_PULL: assert property (pinPullup[2:0] == (pinOe_n[2:0] & pinOut[2:0])) else $error("bad pull");
  AST_KEY: assert property (keyEvtValid |-> ##[1:3] !irqN) else $error("key no irq");
  AST_OVR: assert property (keyOverrun |-> ##[1:3] !irqN) else $error("error no irq");
  AST_SCAN: assert property (scanReq |=> !scanReq) else $error("scan pulse long");
  AST_PCTL: assert property (pulseCtrlStrobe |=> !pulseCtrlStrobe) else $error("strobe long");
  AST_TIMES: assert property (debounceTime != 8'h0 && activeTime != 8'h0) else $error("zero time");
endmodule : khc_host_command_props
bind khc_host_command khc_host_command_props i_props (.*);

// ---- tb/khc_i2c_host.sv ----
// two-wire host master model on the command port
`timescale 1ns/100ps
module khc_i2c_host (
  // bus wires; the clock stands high between frames
  output logic scl,
  output logic sdaDrv,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic bitx(input logic b, output logic s);
    #20 sdaDrv = b;
    #20 scl = 1'b1;
    #20 s = sda;
    #20 scl = 1'b0;
  endtask : bitx
  task automatic xfer(input logic [7:0] d, input logic ackDrv, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(ackDrv, ack);
  endtask : xfer
  task automatic start();
    #20 sdaDrv = 1'b1;
    #20 scl = 1'b1;
    #20 sdaDrv = 1'b0;
    #20 scl = 1'b0;
  endtask : start
  // write address, command, data bytes high first, then optional read phase
  task automatic cmd(input logic [7:0] c, input logic [15:0] d, input int nw, input int nr,
                     output logic [127:0] q, output logic nak);
    logic a;
    logic [7:0] b;
    q = '0;
    #7;
    start();
    xfer({khc_pkg::SLAVE_ADDR, 1'b0}, 1'b1, b, nak);
    xfer(c, 1'b1, b, a);
    nak |= a;
    for (int i = nw; i > 0; i--) begin
      xfer(d[8*i-1 -: 8], 1'b1, b, a);
      nak |= a;
    end
    if (nr > 0) begin
      start();
      xfer({khc_pkg::SLAVE_ADDR, 1'b1}, 1'b1, b, a);
      nak |= a;
      for (int i = 1; i <= nr; i++) begin
        xfer(8'hff, i == nr, b, a);
        q = {q[119:0], b};
      end
    end
    #20 sdaDrv = 1'b0;
    #20 scl = 1'b1;
    #20 sdaDrv = 1'b1;
    #20;
  endtask : cmd
endmodule : khc_i2c_host

// ---- tb/tb.sv ----
// self-checking bench for the host command decoder
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb;
  logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sdaOut, sdaOe_n, irqN, scanReq, halted, pulseCtrlStrobe;
  logic keyEvtValid = 1'b0, keyOverrun = 1'b0, scl, sdaDrv, sda;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, keyEvtCode = 8'h0, debounceTime, activeTime;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] pinIn = 4'h5, pinOut, pinOe_n, pinPullup;
  logic [15:0] phaseATime, phaseBTime;
  logic [2:0] pulseCtrl;
  logic [127:0] rq;
  int error_cnt = 0, checks = 0, cyc = 0, scanCnt = 0;
  always #5 clk = ~clk;
  // pulled-up line: the device can only pull it low
  assign sda = sdaDrv & (sdaOe_n | sdaOut);
  khc_i2c_host i_host (.scl(scl), .sdaDrv(sdaDrv), .sda(sda));
  khc_host_command #(.STEP_CYCLES(20)) i_dut (.*, .wstrb(4'hf), .sclIn(scl), .sdaIn(sda));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cyc++;
    scanCnt += (scanReq === 1'b1) + 16 * (pulseCtrlStrobe === 1'b1);
    if (cyc == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic hc(input logic [7:0] c, input logic [15:0] d, input int nw, input int nr);
    logic nak;
    i_host.cmd(c, d, nw, nr, rq, nak);
    `CHK("ack", 1'b0, nak)
  endtask : hc
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      rs = bresp;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!hb);
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    logic ha, hb;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ha = arvalid & arready;
      hb = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
    end while (!hb);
    rready <= 1'b0;
  endtask : axr
  task automatic t_regs();
    `CHK("pinPullup", 4'h8, pinPullup)
    `CHK("debounce", khc_pkg::DEBOUNCE_DEFAULT, debounceTime)
    axr(khc_pkg::REG_STATUS);
    `CHK("status", 32'h0, rd)
    axw(8'h08, 32'h1);
    `CHK("bresp", khc_pkg::RESP_SLVERR, rs)
    axr(8'h0c);
    `CHK("rresp", khc_pkg::RESP_SLVERR, rs)
    axw(khc_pkg::REG_CTRL, 32'h1);
    axr(khc_pkg::REG_CTRL);
    `CHK("ctrl", 32'h1, rd)
    $display("test regs done");
  endtask : t_regs
  task automatic t_gpio();
    hc(khc_pkg::CMD_PORT_DIR, 16'h00fc, 1, 0);
    hc(khc_pkg::CMD_PORT_OUT, 16'h00fa, 1, 0);
    `CHK("pinOe_n", 4'h3, pinOe_n)
    `CHK("pinOut", 4'ha, pinOut)
    `CHK("pinPullup", 4'h2, pinPullup)
    hc(khc_pkg::CMD_PORT_DIR, 16'h0000, 1, 0);
    hc(khc_pkg::CMD_PORT_OUT, 16'h0000, 1, 0);
    `CHK("pinPullup", 4'h8, pinPullup)
    hc(khc_pkg::CMD_PORT_IN, 16'h0, 0, 1);
    `CHK("port in", 8'h05, rq[7:0])
    $display("test gpio done");
  endtask : t_gpio
  task automatic t_edge();
    hc(khc_pkg::CMD_EDGE_IRQ, 16'h0001, 1, 0); // pins are inputs here
    @(posedge clk) pinIn <= 4'h4;
    repeat (10) @(posedge clk);
    `CHK("irqN", 1'b0, irqN)
    hc(khc_pkg::CMD_READ_INT, 16'h0, 0, 1);
    `CHK("int one pin", 8'h06, rq[7:0])
    `CHK("irqN", 1'b1, irqN)
    hc(khc_pkg::CMD_EDGE_IRQ, 16'h0003, 1, 0);
    @(posedge clk) pinIn <= 4'h6;
    repeat (10) @(posedge clk);
    hc(khc_pkg::CMD_READ_INT, 16'h0, 0, 1);
    `CHK("int pin1", 8'h04, rq[7:0])
    hc(khc_pkg::CMD_DEBOUNCE, 16'h0001, 1, 0);
    hc(khc_pkg::CMD_ACTIVE, 16'h0002, 1, 0); // kept above debounce
    `CHK("debounce", 8'h01, debounceTime)
    `CHK("active", 8'h02, activeTime)
    repeat (100) @(posedge clk);
    `CHK("halted", 1'b1, halted)
    pinIn <= 4'h7;
    repeat (10) @(posedge clk);
    `CHK("woken", 1'b0, halted)
    hc(khc_pkg::CMD_READ_INT, 16'h0, 0, 1);
    `CHK("int pin0", 8'h02, rq[7:0])
    hc(khc_pkg::CMD_ACTIVE, 16'h00ff, 1, 0);
    $display("test edge done");
  endtask : t_edge
  task automatic t_queue();
    for (int i = 0; i < 15; i++) @(posedge clk) {keyEvtValid, keyEvtCode} <= {1'b1, 8'h81 + 8'(i)};
    @(posedge clk) keyEvtValid <= 1'b0;
    hc(khc_pkg::CMD_READ_INT, 16'h0, 0, 1);
    `CHK("int overrun", 8'h09, rq[7:0])
    hc(khc_pkg::CMD_READ_ERROR, 16'h0, 0, 1);
    `CHK("err overrun", 8'h40, rq[7:0])
    hc(khc_pkg::CMD_QUEUE_READ, 16'h0, 0, 16);
    `CHK("queue", 24'h8e0000, rq[23:0])
    `CHK("queue head", 8'h81, rq[127:120])
    hc(khc_pkg::CMD_QUEUE_REREAD, 16'h0, 0, 2);
    `CHK("reread", 16'h8182, rq[15:0])
    $display("test queue done");
  endtask : t_queue
  task automatic t_err();
    hc(8'h55, 16'h0, 0, 0);
    @(posedge clk) keyOverrun <= 1'b1;
    @(posedge clk) keyOverrun <= 1'b0;
    hc(khc_pkg::CMD_READ_INT, 16'h0, 0, 1);
    `CHK("int error", 8'h08, rq[7:0])
    hc(khc_pkg::CMD_READ_ERROR, 16'h0, 0, 1);
    `CHK("err code", 8'h06, rq[7:0])
    hc(khc_pkg::CMD_READ_ERROR, 16'h0, 0, 1);
    `CHK("err clear", 8'h00, rq[7:0])
    hc(khc_pkg::CMD_READ_STATUS, 16'h0, 0, 1);
    `CHK("status", khc_pkg::STAT_ACK, rq[7:0])
    $display("test errors done");
  endtask : t_err
  task automatic t_pulse();
    hc(khc_pkg::CMD_PHASE_A, 16'h1234, 2, 0);
    hc(khc_pkg::CMD_PHASE_B, 16'hbeef, 2, 0);
    hc(khc_pkg::CMD_PULSE_CTRL, 16'h00fd, 1, 0);
    hc(khc_pkg::CMD_SCAN_REQ, 16'h0, 0, 0);
    `CHK("phase a", 16'h1234, phaseATime)
    `CHK("phase b", 16'hbeef, phaseBTime)
    `CHK("pulse ctrl", 3'h5, pulseCtrl)
    `CHK("strobes", 17, scanCnt)
    $display("test pulse done");
  endtask : t_pulse
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_gpio();
    t_edge();
    t_queue();
    t_err();
    t_pulse();
    give_verdict();
  end
endmodule : tb
